/* File: eit_regs.svh */
// register indices, field positions and reset values of the interval timer
`ifndef EIT_REGS_SVH
`define EIT_REGS_SVH
// number of timer instances
`define EIT_N 3
// apb address width, byte address = index * 4
`define EIT_AW 18
`define EIT_IX_W 16
// counter and compare indices per instance
`define EIT_IX_CNT0 16'hff16
`define EIT_IX_CMP0 16'hff17
`define EIT_IX_CNT1 16'hff50
`define EIT_IX_CMP1 16'hff51
`define EIT_IX_CNT2 16'hff52
`define EIT_IX_CMP2 16'hff53
// control registers, one per instance
`define EIT_IX_CTL0 16'hff60
`define EIT_IX_CTL1 16'hff61
`define EIT_IX_CTL2 16'hff62
// interrupt status, enable and clear
`define EIT_IX_STAT 16'hff68
`define EIT_IX_IEN 16'hff69
`define EIT_IX_ICLR 16'hff6a
// control fields
`define EIT_SEL_LSB 0
`define EIT_SEL_MSB 2
`define EIT_RUN_BIT 7
// reset values and constants
`define EIT_CNT_RST 8'h00
`define EIT_CMP_RST 8'h00
`define EIT_ONE 8'h01
`define EIT_ALL 8'hff
`define EIT_ALIGN 2'h0
`endif

/* File: eit_pkg.sv */
// types of the eight-bit interval timer
package eit_pkg;
	// register kind decoded from an apb index
	typedef enum logic [2:0] {
		EK_NONE, EK_CNT, EK_CMP, EK_CTL, EK_STAT, EK_IEN, EK_ICLR
	} eit_kind_t;
	// whole state of the timer block
	typedef struct packed {
		logic [2:0][7:0] cnt;
		logic [2:0][7:0] cmp;
		logic [2:0][2:0] sel;
		logic [2:0] run;
		logic [7:0] pre;
		logic [2:0] stat;
		logic [2:0] ien;
		logic [2:0] mpulse;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} eit_state_t;
endpackage

/* File: eit_timer.sv */
// three eight-bit interval timers behind an apb slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
//
// Contract
// - three identical timers, each fully independent
// - on match counter clears, counts on, interrupts
// - low three control bits pick count clock
// - run bit set starts counting at the next count clock enable
// - run bit cleared halts counting
// - interrupt period is compare plus one count clocks
// - first counter readable, read only, resets zero
// - first compare read write, resets zero
`include "eit_regs.svh"

module eit_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`EIT_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic [2:0] match_interrupt
);
	import eit_pkg::*;

	// ****************************************
	// decode helpers
	// ****************************************

	// register kind of an index
	function automatic eit_pkg::eit_kind_t dec_kind(
		input logic [`EIT_IX_W-1:0] ix);
		dec_kind = EK_NONE;
		if (ix == `EIT_IX_CNT0 || ix == `EIT_IX_CNT1 ||
			ix == `EIT_IX_CNT2) begin
			dec_kind = EK_CNT;
		end
		if (ix == `EIT_IX_CMP0 || ix == `EIT_IX_CMP1 ||
			ix == `EIT_IX_CMP2) begin
			dec_kind = EK_CMP;
		end
		if (ix == `EIT_IX_CTL0 || ix == `EIT_IX_CTL1 ||
			ix == `EIT_IX_CTL2) begin
			dec_kind = EK_CTL;
		end
		if (ix == `EIT_IX_STAT) begin
			dec_kind = EK_STAT;
		end
		if (ix == `EIT_IX_IEN) begin
			dec_kind = EK_IEN;
		end
		if (ix == `EIT_IX_ICLR) begin
			dec_kind = EK_ICLR;
		end
	endfunction

	// instance number of a per-timer index
	function automatic logic [1:0] dec_inst(
		input logic [`EIT_IX_W-1:0] ix);
		dec_inst = 2'h0;
		if (ix == `EIT_IX_CNT1 || ix == `EIT_IX_CMP1 ||
			ix == `EIT_IX_CTL1) begin
			dec_inst = 2'h1;
		end
		if (ix == `EIT_IX_CNT2 || ix == `EIT_IX_CMP2 ||
			ix == `EIT_IX_CTL2) begin
			dec_inst = 2'h2;
		end
	endfunction

	// count clock enable: pclk divided by two to the select
	function automatic logic tick_of(input logic [7:0] pre,
		input logic [2:0] sel);
		logic [7:0] mask;
		mask = ~(`EIT_ALL << sel);
		tick_of = (pre & mask) == mask;
	endfunction

	// ****************************************
	// state and count clock enables
	// ****************************************

	eit_state_t st;
	eit_state_t next_st;
	logic [2:0] tick;
	logic [`EIT_IX_W-1:0] ix;
	eit_kind_t kind;
	logic [1:0] inst;

	assign ix = paddr[`EIT_AW-1:2];
	assign kind = dec_kind(ix);
	assign inst = dec_inst(ix);

	// one enable per timer from the shared prescaler
	genvar g;
	for (g = 0; g < `EIT_N; g++) begin : g_tick
		assign tick[g] = tick_of(st.pre, st.sel[g]);
	end

	// ****************************************
	// next state
	// ****************************************

	// counting, apb access and interrupt bookkeeping
	always_comb begin
		logic acc;
		logic wr;
		logic [2:0] clr;
		logic [7:0] rd;
		logic err;
		next_st = st;
		acc = psel & penable & ~st.pready;
		wr = psel & penable & st.pready & pwrite & ~st.pslverr;
		clr = 3'h0;
		rd = 8'h00;
		// unmapped or unaligned accesses are refused
		err = (kind == EK_NONE) || (paddr[1:0] != `EIT_ALIGN);
		next_st.mpulse = 3'h0;
		next_st.pre = st.pre + `EIT_ONE;
		// timers step on their own enables
		for (int i = 0; i < `EIT_N; i++) begin
			if (st.run[i] && tick[i]) begin
				if (st.cnt[i] == st.cmp[i]) begin
					next_st.cnt[i] = `EIT_CNT_RST;
					next_st.mpulse[i] = 1'b1;
				end else begin
					next_st.cnt[i] = st.cnt[i] + `EIT_ONE;
				end
			end
		end
		// writes take effect on the completing edge
		if (wr) begin
			unique case (kind)
				EK_CMP: begin
					next_st.cmp[inst] = pwdata[7:0];
				end
				EK_CTL: begin
					next_st.sel[inst] =
						pwdata[`EIT_SEL_MSB:`EIT_SEL_LSB];
					next_st.run[inst] = pwdata[`EIT_RUN_BIT];
				end
				EK_IEN: begin
					next_st.ien = pwdata[2:0];
				end
				EK_ICLR: begin
					clr = pwdata[2:0];
				end
				EK_NONE, EK_CNT, EK_STAT: begin
					clr = 3'h0;
				end
			endcase
		end
		// read data gathered in the first access cycle
		unique case (kind)
			EK_CNT: begin
				rd = st.cnt[inst];
			end
			EK_CMP: begin
				rd = st.cmp[inst];
			end
			EK_CTL: begin
				rd = {st.run[inst], 4'h0, st.sel[inst]};
			end
			EK_STAT: begin
				rd = {5'h00, st.stat};
			end
			EK_IEN: begin
				rd = {5'h00, st.ien};
			end
			EK_NONE, EK_ICLR: begin
				rd = 8'h00;
			end
		endcase
		next_st.pready = acc;
		// a refused read returns zero along with the error
		next_st.pslverr = acc & err;
		next_st.prdata = (acc && !pwrite && !err) ?
			{24'h000000, rd} : 32'h0;
		// a new match wins over a clear in the same cycle
		next_st.stat = (st.stat & ~clr) | next_st.mpulse;
		next_st.irq = |(next_st.stat & next_st.ien);
	end

	// ****************************************
	// state register
	// ****************************************

	// all state in one register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign match_interrupt = st.mpulse;

	// ****************************************
	// checks
	// ****************************************

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// apb access: first cycle, then the answered cycle
	sequence s_acc;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence

	// access to the control register of one timer
	sequence s_ctl_wr(logic [`EIT_IX_W-1:0] cix);
		pwrite && paddr[`EIT_AW-1:2] == cix && paddr[1:0] == `EIT_ALIGN
			##0 s_acc;
	endsequence

	// interrupt line follows enabled status
	chk_irq_level: assert property (
		irq == |(st.stat & st.ien))
	else $error("irq does not match enabled status");

	// first counter reads back over the bus
	chk_cnt_read: assert property (
		psel && penable && !pready && !pwrite &&
		paddr == {`EIT_IX_CNT0, `EIT_ALIGN}
		|=> prdata == {24'h000000, $past(st.cnt[0])} && pready)
	else $error("counter read data wrong");

	// first compare takes the written byte
	chk_cmp_write: assert property (
		pwrite && paddr == {`EIT_IX_CMP0, `EIT_ALIGN} ##0 s_acc
		|=> st.cmp[0] == $past(pwdata[7:0]))
	else $error("compare write lost");

	// a completed and accepted write to one index
	sequence s_wr_done(logic [`EIT_IX_W-1:0] wix);
		psel && penable && pready && pwrite && !pslverr &&
			paddr == {wix, `EIT_ALIGN};
	endsequence

	// a count clock enable that meets the compare value
	sequence s_hit(int n);
		st.run[n] && tick[n] && st.cnt[n] == st.cmp[n];
	endsequence

	// the bus answer stands for one cycle only
	chk_ready_pulse: assert property (
		pready |=> !pready)
	else $error("pready held longer than one cycle");

	// a refused access returns no data
	chk_err_data: assert property (
		pslverr |-> pready && prdata == 32'h00000000)
	else $error("refused access returned data");

	// per-timer checks on each instance
	for (g = 0; g < `EIT_N; g++) begin : g_chk
		localparam logic [`EIT_IX_W-1:0] CIX =
			`EIT_IX_CTL0 + `EIT_IX_W'(g);
		localparam logic [`EIT_IX_W-1:0] MIX = (g == 0) ? `EIT_IX_CMP0 :
			(g == 1) ? `EIT_IX_CMP1 : `EIT_IX_CMP2;

		// match clears the counter and pulses once
		chk_match_clear: assert property (
			st.run[g] && tick[g] && st.cnt[g] == st.cmp[g]
			|=> st.cnt[g] == `EIT_CNT_RST && match_interrupt[g])
		else $error("match did not clear counter");

		// counter advances by one on a tick
		chk_count_step: assert property (
			st.run[g] && tick[g] && st.cnt[g] != st.cmp[g]
			|=> st.cnt[g] == $past(st.cnt[g]) + `EIT_ONE)
		else $error("counter did not step");

		// stopped counter holds its value
		chk_hold_stop: assert property (
			!st.run[g] |=> $stable(st.cnt[g]))
		else $error("stopped counter moved");

		// pulse only after a real match
		chk_pulse_cause: assert property (
			match_interrupt[g] |-> st.cnt[g] == `EIT_CNT_RST &&
			$past(st.cnt[g] == st.cmp[g] && st.run[g]) && st.stat[g])
		else $error("pulse without match");

		// slow count clock never ticks twice in a row
		chk_clock_gap: assert property (
			st.sel[g] != 3'h0 && tick[g] && $stable(st.sel[g])
			|=> !tick[g] || st.sel[g] != $past(st.sel[g]))
		else $error("count clock too fast");

		// writing run one starts the timer
		chk_run_start: assert property (
			pwdata[`EIT_RUN_BIT] ##0 s_ctl_wr(CIX) |=> st.run[g])
		else $error("run bit write ignored");

		// writing run zero stops the timer
		chk_run_stop: assert property (
			!pwdata[`EIT_RUN_BIT] ##0 s_ctl_wr(CIX)
			|=> !st.run[g] ##1 $stable(st.cnt[g]))
		else $error("timer did not stop");

		// an enabled match raises irq in the following cycle
		chk_match_irq: assert property (
			s_hit(g) ##1 st.ien[g] |-> irq)
		else $error("match did not raise irq");

		// with a nonzero compare the pulse never repeats at once
		chk_pulse_once: assert property (
			match_interrupt[g] && st.cmp[g] != `EIT_CNT_RST
			|=> !match_interrupt[g])
		else $error("match pulse longer than one cycle");

		// a compare write lands in its own timer and leaves the next timer unchanged
		chk_cmp_own: assert property (
			s_wr_done(MIX) |=> st.cmp[g] == $past(pwdata[7:0]) &&
			$stable(st.cmp[(g + 1) % `EIT_N]))
		else $error("compare write reached wrong timer");

		// status stays set until software clears it
		chk_stat_sticky: assert property (
			st.stat[g] && !(psel && penable && pready && pwrite &&
			!pslverr && paddr == {`EIT_IX_ICLR, `EIT_ALIGN} &&
			pwdata[g]) |=> st.stat[g])
		else $error("status bit lost");

		// a clear without a new match empties the bit
		chk_stat_clear: assert property (
			s_wr_done(`EIT_IX_ICLR) ##0 pwdata[g] &&
			!(st.run[g] && tick[g] && st.cnt[g] == st.cmp[g])
			|=> !st.stat[g])
		else $error("status clear ignored");
	end

endmodule // eit_timer

/* File: test_eight_bit_interval_timer.sv */
// self-checking bench of the eight-bit interval timer
`timescale 1ns/100ps
`include "eit_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end

module test_eight_bit_interval_timer;
	import eit_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [2:0] match_interrupt;
	int fails = 0;
	int checked = 0;
	logic [31:0] q;
	logic [31:0] q2;
	logic e;
	logic [15:0] cnt [3] = '{`EIT_IX_CNT0, `EIT_IX_CNT1, `EIT_IX_CNT2};
	logic [15:0] cmp [3] = '{`EIT_IX_CMP0, `EIT_IX_CMP1, `EIT_IX_CMP2};
	logic [15:0] ctl [3] = '{`EIT_IX_CTL0, `EIT_IX_CTL1, `EIT_IX_CTL2};
	logic [7:0] cv [3] = '{8'hff, 8'h01, 8'h05};
	logic [2:0] sv [3] = '{3'h0, 3'h1, 3'h3};

	// ****************************************
	// clock and device
	// ****************************************
	always #20 pclk = ~pclk;

	eit_timer u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.irq(irq),
		.match_interrupt(match_interrupt)
	); // eit_timer

	// ****************************************
	// bus tasks
	// ****************************************
	// verdict and end of run
	task automatic conclude();
		if (fails == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// one apb transfer, held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [15:0] ix,
		input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, `EIT_ALIGN};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		// values read here are those sampled at this edge
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 40);
		if (pready !== 1'b1) begin
			fails++;
			conclude();
		end else begin
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// read and compare one register
	task automatic rd(input logic [15:0] ix, input logic [7:0] x);
		xfer(1'b0, ix, 8'h00);
		`CHK(q, {24'h000000, x})
		`CHK(e, 1'b0)
	endtask

	// write one register
	task automatic wr(input logic [15:0] ix, input logic [7:0] d);
		xfer(1'b1, ix, d);
		`CHK(e, 1'b0)
	endtask

	// measure pclk cycles between two match pulses of timer n
	task automatic per(input int n, input int p);
		int c;
		c = 0;
		do begin
			@(negedge pclk);
			c++;
		end while (match_interrupt[n] !== 1'b1 && c < 600);
		if (match_interrupt[n] !== 1'b1) begin
			fails++;
			conclude();
		end
		@(negedge pclk);
		`CHK(match_interrupt[n], 1'b0)
		c = 1;
		do begin
			@(negedge pclk);
			c++;
		end while (match_interrupt[n] !== 1'b1 && c < 600);
		if (match_interrupt[n] !== 1'b1) begin
			fails++;
			conclude();
		end
		`CHK(c, p)
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, read-only counter, unmapped index
		for (int n = 0; n < 3; n++) begin
			rd(cnt[n], `EIT_CNT_RST);
			rd(cmp[n], `EIT_CMP_RST);
		end
		wr(cnt[0], 8'h5a);
		rd(cnt[0], 8'h00);
		xfer(1'b0, 16'h0000, 8'h00);
		`CHK(e, 1'b1)
		`CHK(q, 32'h00000000)
		// three timers with their own clock and compare
		wr(`EIT_IX_IEN, 8'h00);
		wr(`EIT_IX_ICLR, 8'h07);
		for (int n = 0; n < 3; n++) begin
			wr(cmp[n], cv[n]);
			rd(cmp[n], cv[n]);
			wr(ctl[n], 8'h80 | {5'h00, sv[n]});
			rd(ctl[n], 8'h80 | {5'h00, sv[n]});
		end
		for (int n = 0; n < 3; n++) begin
			per(n, (int'(cv[n]) + 1) << sv[n]);
		end
		`CHK(irq, 1'b0)
		rd(`EIT_IX_STAT, 8'h07);
		wr(`EIT_IX_IEN, 8'h01);
		rd(`EIT_IX_IEN, 8'h01);
		repeat (2) @(negedge pclk);
		`CHK(irq, 1'b1)
		// stopped counter of timer 2 holds at or below compare
		for (int n = 0; n < 3; n++) begin
			wr(ctl[n], 8'h00);
		end
		xfer(1'b0, cnt[2], 8'h00);
		`CHK(q[7:0] <= 8'h05, 1'b1)
		q2 = q;
		repeat (20) @(negedge pclk);
		rd(cnt[2], q2[7:0]);
		wr(`EIT_IX_ICLR, 8'h07);
		rd(`EIT_IX_STAT, 8'h00);
		repeat (2) @(negedge pclk);
		`CHK(irq, 1'b0)
		// every clock select code on timer 1
		wr(cmp[1], cv[1]);
		wr(`EIT_IX_IEN, 8'h02);
		for (int s = 0; s < 8; s++) begin
			wr(ctl[1], 8'h80 | 8'(s));
			per(1, 2 << s);
			wr(ctl[1], 8'h00);
		end
		rd(`EIT_IX_STAT, 8'h02);
		`CHK(irq, 1'b1)
		conclude();
	end
endmodule // test_eight_bit_interval_timer
